// >>> dv/sbl_slave_model.sv
`timescale 1ns/1ps
// ==========================================================
// slave model: answers each read after three cycles
module sbl_slave_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        slave_req,
  input  wire logic        slave_we,
  input  wire logic [17:0] slave_addr,
  output logic             slave_rvalid,
  output logic      [35:0] slave_read_bus
);
  logic [1:0] cnt;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 2'h0;
      slave_rvalid <= 1'b0;
      slave_read_bus <= 36'h0;
    end else begin
      slave_rvalid <= 1'b0;
      // outside an answer the data never holds its last value
      slave_read_bus <= ~slave_read_bus;
      if (slave_req && !slave_we) cnt <= 2'h3;
      else if (cnt != 2'h0) cnt <= cnt - 2'h1;
      if (cnt == 2'h1) begin
        slave_rvalid <= 1'b1;
        slave_read_bus <= {18'h2a5c3, slave_addr};
      end
    end
  end
endmodule

// >>> dv/sbl_system_bus_test.sv
`timescale 1ns/1ps
module sbl_system_bus_test;
  import sbl_pkg::*;
  logic mclk = 0, reset_n = 0, parity_enable = 0, cfg_irq_event = 0, cfg_err_event = 0;
  logic [2:0] clock_source_strap = 0;
  sbl_clk_src_type bus_clock_source;
  sbl_master_type grant = sbl_m_fab;
  sbl_width_type host_width = sbl_w8, fabric_width = sbl_w8, embedded_asic_port_width = sbl_w8;
  logic host_req = 0, host_we = 0, fabric_req = 0, fabric_we = 0;
  logic embedded_asic_port_req = 0, embedded_asic_port_we = 0;
  logic host_rvalid, host_irq_n, fabric_rvalid, fabric_irq, embedded_asic_port_rvalid;
  logic embedded_asic_port_irq, slave_req, slave_we, slave_rvalid;
  logic [14:31] host_addr = 0;
  logic [0:31] host_wdata = 0, host_rdata;
  logic [1:4] host_wpar = 0, host_rpar;
  logic [17:0] fabric_addr = 0, embedded_asic_port_addr = 0, slave_addr;
  logic [35:0] fabric_master_data = 0, embedded_asic_port_wdata = 0, r;
  logic [35:0] fabric_master_read_data, embedded_asic_port_rdata, slave_wdata, slave_read_bus;
  logic [3:0] fabric_irq_event = 0;
  logic [1:0] embedded_asic_port_irq_event = 0;
  int bad_count = 0, checks = 0, cyc = 0;
  logic [17:0] wa[3] = '{18'h08001, 18'h08003, 18'h08007};
  logic [17:0] xa[3] = '{18'h08001, 18'h08002, 18'h08004};
  logic [35:0] wd[3] = '{36'h1000000a5, 36'h200001234, 36'h5deadbeef};
  logic [35:0] xd[3] = '{36'hfa5a5a5a5, 36'ha12341234, 36'h5deadbeef};
  sbl_width_type ww[3] = '{sbl_w8, sbl_w16, sbl_w32};

  sbl_system_bus u_dut (.*);
  sbl_slave_model u_slave (.*);

  always #25 mclk = ~mclk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access by master m; all masters see the same fields, only m requests
  task automatic acc(input sbl_master_type m, input logic we, input sbl_width_type w,
                     input logic [17:0] a, input logic [35:0] d, output logic [35:0] q);
    int n;
    logic v;
    logic [31:0] rd;
    logic [3:0] rp;
    @(negedge mclk);
    grant = m;
    host_we = we;
    fabric_we = we;
    embedded_asic_port_we = we;
    host_width = w;
    fabric_width = w;
    embedded_asic_port_width = w;
    host_addr = a;
    fabric_addr = a;
    embedded_asic_port_addr = a;
    host_wdata = {<<{d[31:0]}};
    host_wpar = {<<{d[35:32]}};
    fabric_master_data = d;
    embedded_asic_port_wdata = d;
    host_req = m == sbl_m_host;
    fabric_req = m == sbl_m_fab;
    embedded_asic_port_req = m == sbl_m_asic;
    @(negedge mclk);
    host_req = 0;
    fabric_req = 0;
    embedded_asic_port_req = 0;
    // rvalid stands one cycle: look at every falling edge from the one after the take
    n = 0;
    v = m == sbl_m_host ? host_rvalid : m == sbl_m_fab ? fabric_rvalid : embedded_asic_port_rvalid;
    while (!we && v !== 1'b1 && n < 20) begin
      @(negedge mclk);
      v = m == sbl_m_host ? host_rvalid : m == sbl_m_fab ? fabric_rvalid : embedded_asic_port_rvalid;
      n++;
    end
    if (!we) chk(v, 1);
    rd = {<<{host_rdata}};
    rp = {<<{host_rpar}};
    q = m == sbl_m_host ? {rp, rd} : m == sbl_m_fab ? fabric_master_read_data : embedded_asic_port_rdata;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1;
    acc(sbl_m_fab, 0, sbl_w32, 18'h00010, 0, r);
    chk(r[31:0], 0);
    chk(host_irq_n, 1);
    acc(sbl_m_fab, 1, sbl_w8, 18'h00013, 36'h03, r);
    cfg_irq_event = 1;
    cfg_err_event = 1;
    @(negedge mclk);
    cfg_irq_event = 0;
    cfg_err_event = 0;
    chk({host_irq_n, fabric_irq}, 0);
    acc(sbl_m_host, 0, sbl_w8, 18'h00010, 0, r);
    chk(r, 36'h03);
    acc(sbl_m_host, 1, sbl_w8, 18'h00010, 36'h01, r);
    chk(host_irq_n, 0);
    acc(sbl_m_host, 1, sbl_w8, 18'h00010, 36'h02, r);
    chk(host_irq_n, 1);
    cfg_irq_event = 1;
    acc(sbl_m_host, 1, sbl_w8, 18'h00010, 36'h01, r);
    cfg_irq_event = 0;
    acc(sbl_m_fab, 0, sbl_w8, 18'h00010, 0, r);
    chk(r[7:0], 8'h01);
    acc(sbl_m_fab, 1, sbl_w8, 18'h00010, 36'h01, r);
    $display("interrupt cause tests done");
    acc(sbl_m_fab, 1, sbl_w8, 18'h00011, 36'h04, r);
    fabric_irq_event = 4'h1;
    @(negedge mclk);
    fabric_irq_event = 0;
    chk({fabric_irq, host_irq_n, embedded_asic_port_irq}, 3'b110);
    acc(sbl_m_asic, 1, sbl_w8, 18'h00012, 36'h40, r);
    embedded_asic_port_irq_event = 2'h1;
    @(negedge mclk);
    embedded_asic_port_irq_event = 0;
    chk(embedded_asic_port_irq, 1);
    parity_enable = 1;
    acc(sbl_m_fab, 0, sbl_w32, 18'h00013, 0, r);
    chk(r, 36'h644044003);
    acc(sbl_m_asic, 0, sbl_w16, 18'h00011, 0, r);
    chk({r[33:32], r[15:0]}, 18'h14404);
    $display("enable and parity tests done");
    for (int i = 0; i < 3; i++) begin
      acc(sbl_m_fab, 1, ww[i], wa[i], wd[i], r);
      chk({slave_req, slave_we, slave_addr, slave_wdata}, {2'b11, xa[i], xd[i]});
    end
    acc(sbl_m_host, 1, sbl_w8, 18'h08000, 36'h80, r);
    chk({slave_addr, slave_wdata}, {18'h08000, 36'h080808080});
    acc(sbl_m_host, 1, sbl_w32, 18'h08006, 36'h1000000ff, r);
    chk({slave_addr, slave_wdata}, {18'h08004, 36'h1000000ff});
    acc(sbl_m_fab, 0, sbl_w32, 18'h08010, 0, r);
    chk(r, {18'h2a5c3, 18'h08010});
    acc(sbl_m_host, 0, sbl_w32, 18'h08020, 0, r);
    chk(r, {18'h2a5c3, 18'h08020});
    $display("data path tests done");
    clock_source_strap = 3'h5;
    repeat (4) @(negedge mclk);
    chk(bus_clock_source, sbl_src_oscillator);
    clock_source_strap = 3'h7;
    repeat (4) @(negedge mclk);
    chk(bus_clock_source, sbl_src_config_clock);
    $display("clock source tests done");
    test_done();
  end
endmodule

// >>> verilog/sbl_defs.svh
`ifndef SBL_DEFS_SVH
`define SBL_DEFS_SVH

// ==========================================================
// bus geometry
`define SBL_ADDR_W        18
`define SBL_DATA_W        32
`define SBL_BUS_W         36
`define SBL_PAR_LSB       32
`define SBL_BYTE_W        8
`define SBL_LANES         4
`define SBL_MASTERS       3
`define SBL_SRC_W         3
`define SBL_HOST_ADDR_MSB 14
`define SBL_HOST_ADDR_LSB 31

// ==========================================================
// built-in interrupt registers
`define SBL_CAUSE_ADDR    18'h00010
`define SBL_EN_FAB_ADDR   18'h00011
`define SBL_EN_ASIC_ADDR  18'h00012
`define SBL_EN_HOST_ADDR  18'h00013
`define SBL_REG_WORD      16'h0004
`define SBL_REG_W         8
`define SBL_REG_RESET     8'h00

// ==========================================================
// cause bit layout
`define SBL_CFG_IRQ_BIT   0
`define SBL_CFG_ERR_BIT   1
`define SBL_FAB_IRQ_LSB   2
`define SBL_FAB_IRQ_N     4
`define SBL_ASIC_IRQ_LSB  6
`define SBL_ASIC_IRQ_N    2

`endif

// >>> verilog/sbl_host_order.sv
`timescale 1ns/1ps
`include "sbl_defs.svh"
module sbl_host_order (
  input  wire logic [`SBL_HOST_ADDR_MSB:`SBL_HOST_ADDR_LSB] host_addr,
  input  wire logic [0:`SBL_DATA_W-1]                       host_wdata,
  input  wire logic [1:`SBL_LANES]                          host_wpar,
  input  wire logic [`SBL_BUS_W-1:0]                        int_rdata,
  output logic      [`SBL_ADDR_W-1:0]                       int_addr,
  output logic      [`SBL_BUS_W-1:0]                        int_wdata,
  output logic      [0:`SBL_DATA_W-1]                       host_rdata,
  output logic      [1:`SBL_LANES]                          host_rpar
);
  // ==========================================================
  // host address bit 31 is the bus lsb
  for (genvar i = 0; i < `SBL_ADDR_W; i++) begin : g_addr
    assign int_addr[i] = host_addr[`SBL_HOST_ADDR_LSB-i];
  end

  // ==========================================================
  // data pin n is bus bit n, no reordering
  for (genvar n = 0; n < `SBL_DATA_W; n++) begin : g_data
    assign int_wdata[n]  = host_wdata[n];
    assign host_rdata[n] = int_rdata[n];
  end

  for (genvar p = 1; p <= `SBL_LANES; p++) begin : g_par
    assign int_wdata[`SBL_PAR_LSB+p-1] = host_wpar[p];
    assign host_rpar[p] = int_rdata[`SBL_PAR_LSB+p-1];
  end
endmodule

// >>> verilog/sbl_lane_pack.sv
`timescale 1ns/1ps
`include "sbl_defs.svh"
module sbl_lane_pack
  import sbl_pkg::*;
(
  input  wire sbl_pkg::sbl_width_type width,
  input  wire logic [`SBL_ADDR_W-1:0] addr_in,
  input  wire logic [`SBL_BUS_W-1:0]  data_in,
  output logic      [`SBL_ADDR_W-1:0] addr_out,
  output logic      [`SBL_BUS_W-1:0]  data_out
);
  // ==========================================================
  // alignment and byte lane replication by master width
  always_comb begin
    addr_out = addr_in;
    data_out = data_in;
    case (width)
      sbl_w32: begin
        addr_out[1:0] = 2'h0;
      end
      sbl_w16: begin
        addr_out[0] = 1'b0;
        data_out[31:16] = data_in[15:0];
        data_out[35:34] = data_in[33:32];
      end
      sbl_w8: begin
        data_out[31:8]  = {3{data_in[7:0]}};
        data_out[35:33] = {3{data_in[`SBL_PAR_LSB]}};
      end
      default: begin
        addr_out = addr_in;
      end
    endcase
  end
endmodule

// >>> verilog/sbl_pkg.sv
package sbl_pkg;
  `include "sbl_defs.svh"

  typedef enum logic [1:0] {
    sbl_w8  = 2'h0,
    sbl_w16 = 2'h1,
    sbl_w32 = 2'h2
  } sbl_width_type;

  typedef enum logic [1:0] {
    sbl_m_host = 2'h0,
    sbl_m_fab  = 2'h1,
    sbl_m_asic = 2'h2
  } sbl_master_type;

  typedef enum logic [2:0] {
    sbl_src_config_clock = 3'h0,
    sbl_src_jtag         = 3'h1,
    sbl_src_host         = 3'h2,
    sbl_src_asic         = 3'h3,
    sbl_src_user         = 3'h4,
    sbl_src_oscillator   = 3'h5
  } sbl_clk_src_type;

  typedef struct packed {
    logic [`SBL_REG_W-1:0]   cause;
    logic [`SBL_REG_W-1:0]   en_fab;
    logic [`SBL_REG_W-1:0]   en_asic;
    logic [`SBL_REG_W-1:0]   en_host;
    logic                    host_irq_n;
    logic                    fab_irq;
    logic                    asic_irq;
    logic                    slv_req;
    logic                    slv_we;
    logic [`SBL_ADDR_W-1:0]  slv_addr;
    logic [`SBL_BUS_W-1:0]   slv_wdata;
    sbl_width_type           slv_width;
    logic [`SBL_BUS_W-1:0]   rd_data;
    logic [`SBL_MASTERS-1:0] rvalid;
    logic                    busy;
    sbl_master_type          owner;
    logic [`SBL_SRC_W-1:0]   src_sync1;
    logic [`SBL_SRC_W-1:0]   src_sync2;
    sbl_clk_src_type         clk_src;
  } sbl_state_type;
endpackage

// >>> verilog/sbl_system_bus.sv
`timescale 1ns/1ps
`include "sbl_defs.svh"
module sbl_system_bus
  import sbl_pkg::*;
(
  input  wire logic                                         mclk,
  input  wire logic                                         reset_n,
  input  wire logic [`SBL_SRC_W-1:0]                        clock_source_strap,
  output sbl_pkg::sbl_clk_src_type                          bus_clock_source,
  input  wire logic                                         parity_enable,
  input  wire sbl_pkg::sbl_master_type                      grant,
  input  wire logic                                         host_req,
  input  wire logic                                         host_we,
  input  wire sbl_pkg::sbl_width_type                       host_width,
  input  wire logic [`SBL_HOST_ADDR_MSB:`SBL_HOST_ADDR_LSB] host_addr,
  input  wire logic [0:`SBL_DATA_W-1]                       host_wdata,
  input  wire logic [1:`SBL_LANES]                          host_wpar,
  output logic      [0:`SBL_DATA_W-1]                       host_rdata,
  output logic      [1:`SBL_LANES]                          host_rpar,
  output logic                                              host_rvalid,
  output logic                                              host_irq_n,
  input  wire logic                                         fabric_req,
  input  wire logic                                         fabric_we,
  input  wire sbl_pkg::sbl_width_type                       fabric_width,
  input  wire logic [`SBL_ADDR_W-1:0]                       fabric_addr,
  input  wire logic [`SBL_BUS_W-1:0]                        fabric_master_data,
  output logic      [`SBL_BUS_W-1:0]                        fabric_master_read_data,
  output logic                                              fabric_rvalid,
  output logic                                              fabric_irq,
  input  wire logic                                         embedded_asic_port_req,
  input  wire logic                                         embedded_asic_port_we,
  input  wire sbl_pkg::sbl_width_type                       embedded_asic_port_width,
  input  wire logic [`SBL_ADDR_W-1:0]                       embedded_asic_port_addr,
  input  wire logic [`SBL_BUS_W-1:0]                        embedded_asic_port_wdata,
  output logic      [`SBL_BUS_W-1:0]                        embedded_asic_port_rdata,
  output logic                                              embedded_asic_port_rvalid,
  output logic                                              embedded_asic_port_irq,
  input  wire logic                                         cfg_irq_event,
  input  wire logic                                         cfg_err_event,
  input  wire logic [`SBL_FAB_IRQ_N-1:0]                    fabric_irq_event,
  input  wire logic [`SBL_ASIC_IRQ_N-1:0]                   embedded_asic_port_irq_event,
  output logic                                              slave_req,
  output logic                                              slave_we,
  output logic      [`SBL_ADDR_W-1:0]                       slave_addr,
  output logic      [`SBL_BUS_W-1:0]                        slave_wdata,
  input  wire logic                                         slave_rvalid,
  input  wire logic [`SBL_BUS_W-1:0]                        slave_read_bus
);
  import sbl_pkg::*;

  sbl_state_type           st;
  sbl_state_type           next_st;
  logic [`SBL_ADDR_W-1:0]  host_int_addr;
  logic [`SBL_BUS_W-1:0]   host_int_wdata;
  logic [`SBL_ADDR_W-1:0]  host_al_addr;
  logic [`SBL_BUS_W-1:0]   host_al_data;
  logic [`SBL_ADDR_W-1:0]  fab_al_addr;
  logic [`SBL_BUS_W-1:0]   fab_al_data;
  logic [`SBL_ADDR_W-1:0]  asic_al_addr;
  logic [`SBL_BUS_W-1:0]   asic_al_data;
  logic                    m_req;
  logic                    m_we;
  sbl_width_type           m_width;
  logic [`SBL_ADDR_W-1:0]  m_addr;
  logic [`SBL_BUS_W-1:0]   m_data;
  logic                    reg_hit;
  logic [`SBL_REG_W-1:0]   set;
  logic [`SBL_REG_W-1:0]   clr;
  logic [`SBL_BUS_W-1:0]   reg_rd;

  // ==========================================================
  // host ordering and per-master lane packing
  sbl_host_order u_host_order (
    .host_addr  (host_addr),
    .host_wdata (host_wdata),
    .host_wpar  (host_wpar),
    .int_rdata  (st.rd_data),
    .int_addr   (host_int_addr),
    .int_wdata  (host_int_wdata),
    .host_rdata (host_rdata),
    .host_rpar  (host_rpar)
  );

  sbl_lane_pack u_host_lanes (
    .width    (host_width),
    .addr_in  (host_int_addr),
    .data_in  (host_int_wdata),
    .addr_out (host_al_addr),
    .data_out (host_al_data)
  );

  sbl_lane_pack u_fab_lanes (
    .width    (fabric_width),
    .addr_in  (fabric_addr),
    .data_in  (fabric_master_data),
    .addr_out (fab_al_addr),
    .data_out (fab_al_data)
  );

  sbl_lane_pack u_asic_lanes (
    .width    (embedded_asic_port_width),
    .addr_in  (embedded_asic_port_addr),
    .data_in  (embedded_asic_port_wdata),
    .addr_out (asic_al_addr),
    .data_out (asic_al_data)
  );

  // ==========================================================
  // register byte placement
  function automatic logic lane_covered(sbl_width_type w, logic [1:0] a, logic [1:0] j);
    case (w)
      sbl_w32: lane_covered = 1'b1;
      sbl_w16: lane_covered = (j[1] == a[1]);
      sbl_w8:  lane_covered = (j == a);
      default: lane_covered = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] lane_of(sbl_width_type w, logic [1:0] j);
    case (w)
      sbl_w32: lane_of = 2'h3 - j;
      sbl_w16: lane_of = {1'b0, ~j[0]};
      default: lane_of = 2'h0;
    endcase
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic [1:0]            ln;
    logic [`SBL_REG_W-1:0] byte_v;
    logic [`SBL_REG_W-1:0] reg_v;
    ln      = 2'h0;
    byte_v  = `SBL_REG_RESET;
    reg_v   = `SBL_REG_RESET;
    next_st = st;
    next_st.slv_req = 1'b0;
    next_st.rvalid  = '0;

    // strap passes two sync flops and the decoded clk_src flop, unknown codes fall back to config clock
    next_st.src_sync1 = clock_source_strap;
    next_st.src_sync2 = st.src_sync1;
    case (st.src_sync2)
      sbl_src_jtag, sbl_src_host, sbl_src_asic, sbl_src_user,
      sbl_src_oscillator: next_st.clk_src = sbl_clk_src_type'(st.src_sync2);
      default:            next_st.clk_src = sbl_src_config_clock;

    endcase

    // granted master onto the bus; address is the same 17:0 for all
    case (grant)
      sbl_m_host: begin
        m_req = host_req; m_we = host_we; m_width = host_width;
        m_addr = host_al_addr; m_data = host_al_data;
      end
      sbl_m_fab: begin
        m_req = fabric_req; m_we = fabric_we; m_width = fabric_width;
        m_addr = fab_al_addr; m_data = fab_al_data;
      end
      sbl_m_asic: begin
        m_req = embedded_asic_port_req; m_we = embedded_asic_port_we;
        m_width = embedded_asic_port_width;
        m_addr = asic_al_addr; m_data = asic_al_data;
      end
      default: begin
        m_req = 1'b0; m_we = 1'b0; m_width = sbl_w8;
        m_addr = '0; m_data = '0;
      end
    endcase
    reg_hit = (m_addr[`SBL_ADDR_W-1:2] == `SBL_REG_WORD);

    // interrupt sources
    set = '0;
    set[`SBL_CFG_IRQ_BIT] = cfg_irq_event;
    set[`SBL_CFG_ERR_BIT] = cfg_err_event;
    set[`SBL_FAB_IRQ_LSB +: `SBL_FAB_IRQ_N] = fabric_irq_event;
    set[`SBL_ASIC_IRQ_LSB +: `SBL_ASIC_IRQ_N] = embedded_asic_port_irq_event;

    // built-in register access, one register per byte address
    clr    = '0;
    reg_rd = '0;
    for (int j = 0; j < `SBL_LANES; j++) begin
      if (lane_covered(m_width, m_addr[1:0], 2'(j))) begin
        ln     = lane_of(m_width, 2'(j));
        byte_v = m_data[ln*`SBL_BYTE_W +: `SBL_BYTE_W];
        case (j)
          0:       reg_v = st.cause;
          1:       reg_v = st.en_fab;
          2:       reg_v = st.en_asic;
          default: reg_v = st.en_host;
        endcase
        reg_rd[ln*`SBL_BYTE_W +: `SBL_BYTE_W] = reg_v;
        if (m_req && m_we && reg_hit) begin
          case (j)
            0:       clr = byte_v;
            1:       next_st.en_fab = byte_v;
            2:       next_st.en_asic = byte_v;
            default: next_st.en_host = byte_v;
          endcase
        end
      end
    end
    // read parity is generated only for built-in registers, slave reads pass slave_read_bus bits 35:32; nothing checks it
    for (int k = 0; k < `SBL_LANES; k++) begin
      reg_rd[`SBL_PAR_LSB+k] = parity_enable & (^reg_rd[k*`SBL_BYTE_W +: `SBL_BYTE_W]);
    end

    next_st.cause = (st.cause & ~clr) | set;

    if (m_req && reg_hit && !m_we) begin
      next_st.rd_data = reg_rd;
      next_st.rvalid[grant] = 1'b1;
    end

    // slave path: one outstanding read, new requests ignored while busy
    if (m_req && !reg_hit && !st.busy) begin
      next_st.slv_req   = 1'b1;
      next_st.slv_we    = m_we;
      next_st.slv_addr  = m_addr;
      next_st.slv_wdata = m_data;
      next_st.slv_width = m_width;
      if (!m_we) begin
        next_st.busy  = 1'b1;
        next_st.owner = grant;
      end
    end
    if (st.busy && slave_rvalid) begin
      next_st.rd_data = slave_read_bus;
      next_st.rvalid[st.owner] = 1'b1;
      next_st.busy = 1'b0;
    end

    next_st.host_irq_n = ~|(next_st.cause & next_st.en_host);
    next_st.fab_irq    = |(next_st.cause & next_st.en_fab);
    next_st.asic_irq   = |(next_st.cause & next_st.en_asic);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st            <= '0;
      st.host_irq_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign bus_clock_source          = st.clk_src;
  assign host_rvalid               = st.rvalid[sbl_m_host];
  assign host_irq_n                = st.host_irq_n;
  assign fabric_master_read_data   = st.rd_data;
  assign fabric_rvalid             = st.rvalid[sbl_m_fab];
  assign fabric_irq                = st.fab_irq;
  assign embedded_asic_port_rdata  = st.rd_data;
  assign embedded_asic_port_rvalid = st.rvalid[sbl_m_asic];
  assign embedded_asic_port_irq    = st.asic_irq;
  assign slave_req                 = st.slv_req;
  assign slave_we                  = st.slv_we;
  assign slave_addr                = st.slv_addr;
  assign slave_wdata               = st.slv_wdata;

  // ==========================================================
  // checks
  property p_osc_select;
    @(posedge mclk) disable iff (!reset_n)
    (clock_source_strap == sbl_src_oscillator) [*3] |=> (st.clk_src == sbl_src_oscillator);
  endproperty
  a_osc_select: assert property (p_osc_select) else $error("oscillator source not selected");

  property p_cause_set;
    @(posedge mclk) disable iff (!reset_n)
    (set != 8'h00) |=> ((st.cause & $past(set)) == $past(set));
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause bit not set by event");

  property p_cause_hold;
    @(posedge mclk) disable iff (!reset_n)
    1'b1 |=> (($past(st.cause) & ~st.cause & ~$past(clr)) == 8'h00);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause bit fell without write");

  property p_cause_clear;
    @(posedge mclk) disable iff (!reset_n)
    ((clr != 8'h00) && ((clr & set) == 8'h00)) |=> ((st.cause & $past(clr)) == 8'h00);
  endproperty
  a_cause_clear: assert property (p_cause_clear) else $error("written one did not clear");

  property p_host_irq;
    @(posedge mclk) disable iff (!reset_n)
    st.host_irq_n == ((st.cause & st.en_host) == 8'h00);
  endproperty
  a_host_irq: assert property (p_host_irq) else $error("host interrupt level wrong");

  property p_fab_irq;
    @(posedge mclk) disable iff (!reset_n)
    (st.fab_irq != $past(st.fab_irq)) |-> (st.fab_irq == ((st.cause & st.en_fab) != 8'h00));
  endproperty
  a_fab_irq: assert property (p_fab_irq) else $error("fabric interrupt level wrong");

  property p_cfg_to_host;
    @(posedge mclk) disable iff (!reset_n)
    (cfg_irq_event && cfg_err_event && st.en_host[`SBL_CFG_IRQ_BIT] && st.en_host[`SBL_CFG_ERR_BIT])
      |=> (!st.host_irq_n && st.cause[`SBL_CFG_IRQ_BIT] && st.cause[`SBL_CFG_ERR_BIT]);
  endproperty
  a_cfg_to_host: assert property (p_cfg_to_host) else $error("config event missed host");

  property p_align;
    @(posedge mclk) disable iff (!reset_n)
    st.slv_req |-> !((st.slv_width == sbl_w32) && (st.slv_addr[1:0] != 2'h0))
                && !((st.slv_width == sbl_w16) && st.slv_addr[0]);
  endproperty
  a_align: assert property (p_align) else $error("slave address not aligned");

  property p_repl;
    @(posedge mclk) disable iff (!reset_n)
    (st.slv_req && (st.slv_width == sbl_w8)) |-> (st.slv_wdata[31:8] == {3{st.slv_wdata[7:0]}})
      && (st.slv_wdata[35:33] == {3{st.slv_wdata[32]}});
  endproperty
  a_repl: assert property (p_repl) else $error("byte lanes not replicated");

  property p_slave_read;
    @(posedge mclk) disable iff (!reset_n)
    (st.busy && slave_rvalid) |=> (st.rd_data == $past(slave_read_bus)) && (st.rvalid != 3'h0) && !st.busy;
  endproperty
  a_slave_read: assert property (p_slave_read) else $error("read data altered");
endmodule
